// [design/rwts_width_select.sv]
// register width and type select engine for a serial slave
// assumes a framer presents decoded requests and pushes write words;
// the parameter store answers reads combinationally from paramAddr; data is sampled on every read step, paramRdEn rises only on narrow or high-word steps
`timescale 1ns/1ns
`include "rwts_defs.svh"
module rwts_width_select
  import rwts_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        reqValid,
  input  wire logic [7:0]  reqFunc,
  input  wire logic [15:0] reqAddr,
  input  wire logic [15:0] reqCount,
  input  wire logic        wrWordValid,
  input  wire logic [15:0] wrWord,
  input  wire logic [31:0] paramRdData,
  input  wire logic        paramIs32,
  input  wire logic signed [31:0] paramMin,
  input  wire logic signed [31:0] paramMax,
  output logic             reqReady,
  output logic             paramRdEn,
  output logic             paramWrEn,
  output logic      [13:0] paramAddr,
  output logic      [31:0] paramWrData,
  output logic             rdWordValid,
  output logic      [15:0] rdWord,
  output logic             wrRejected,
  output logic             excValid,
  output logic      [7:0]  excFunc,
  output logic      [7:0]  excCode,
  output logic             doneValid,
  output logic      [15:0] doneCount,
  output logic      [15:0] crcValue
);
  rwts_state_t state_reg;
  rwts_type_t  decType;
  rwts_type_t  blkType_reg;
  logic [13:0] decIndex;
  logic        decWide;
  logic [7:0]  decExc;
  logic [15:0] left_reg;
  logic        half_reg;
  logic [15:0] hiWord_reg;
  logic [31:0] wideValue;
  logic [15:0] wrCnt_reg;
  logic        blkWide;
  logic        inRange;
  logic        rdStep;
  logic        wrStep;
  logic        funcKnown;

  rwts_decode u_decode (
    .startAddr  (reqAddr),
    .regCount   (reqCount),
    .funcCode   (reqFunc),
    .selType    (decType),
    .paramIndex (decIndex),
    .isWide     (decWide),
    .excCode    (decExc)
  );

  rwts_crc16 u_crc (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .crcClear     (reqValid && reqReady),
    .crcByteValid (rdWordValid),
    .crcByte      (rdWord[7:0]),
    .crcValue     (crcValue)
  );

  assign blkWide   = (blkType_reg == RWTS_INT32) || (blkType_reg == RWTS_FLOAT32);
  assign wideValue = {hiWord_reg, wrWord};
  assign inRange   = paramIs32 || (($signed(wideValue) >= paramMin)
                     && ($signed(wideValue) <= paramMax));
  assign rdStep    = (state_reg == RWTS_READ) && (left_reg != 16'h0000);
  assign wrStep    = (state_reg == RWTS_WRITE) && wrWordValid && (left_reg != 16'h0000);
  assign funcKnown = reqFunc inside {`RWTS_FC_READ, `RWTS_FC_WRSINGLE, `RWTS_FC_WRMULTI,
                                     `RWTS_FC_RDWR};

  // block state
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg   <= RWTS_IDLE;
      blkType_reg <= RWTS_INT16;
      left_reg    <= 16'h0000;
      reqReady    <= 1'b1;
    end
    else
    begin
      case (state_reg)
        RWTS_IDLE:
        begin
          if (reqValid)
          begin
            blkType_reg <= decType;
            left_reg    <= reqCount;
            reqReady    <= 1'b0;
            if (decExc != `RWTS_EXC_NONE)
              state_reg <= RWTS_ERR;
            else if (reqFunc == `RWTS_FC_READ)
              state_reg <= RWTS_READ;
            else
              state_reg <= RWTS_WRITE;
          end
        end
        RWTS_READ:
        begin
          if (left_reg == 16'h0000)
            state_reg <= RWTS_DONE;
          else
            left_reg <= left_reg - 16'h0001;
        end
        RWTS_WRITE:
        begin
          if (left_reg == 16'h0000)
            state_reg <= RWTS_DONE;
          else if (wrStep && blkWide && half_reg && !inRange)
            state_reg <= RWTS_DONE;
          else if (wrStep)
            left_reg <= left_reg - 16'h0001;
        end
        RWTS_DONE, RWTS_ERR:
        begin
          state_reg <= RWTS_IDLE;
          reqReady  <= 1'b1;
        end
        default:
        begin
          state_reg <= RWTS_IDLE;
          reqReady  <= 1'b1;
        end
      endcase
    end
  end

  // word half and parameter pointer
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      half_reg   <= 1'b0;
      paramAddr  <= 14'h0000;
      hiWord_reg <= 16'h0000;
    end
    else if (state_reg == RWTS_IDLE && reqValid)
    begin
      half_reg  <= 1'b0;
      paramAddr <= decIndex;
    end
    else if (rdStep || wrStep)
    begin
      if (!blkWide)
        paramAddr <= paramAddr + 14'h0001;
      else
      begin
        half_reg <= !half_reg;
        if (half_reg)
          paramAddr <= paramAddr + 14'h0001;
        else if (wrStep)
          hiWord_reg <= wrWord;
      end
    end
  end

  // read data shaping
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdWordValid <= 1'b0;
      rdWord      <= 16'h0000;
    end
    else
    begin
      rdWordValid <= rdStep;
      if (rdStep && !blkWide)
        rdWord <= paramRdData[15:0];
      else if (rdStep && !half_reg)
        rdWord <= paramIs32 ? paramRdData[31:16] : {16{paramRdData[15]}};
      else if (rdStep)
        rdWord <= paramRdData[15:0];
    end
  end

  // parameter store strobes
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      paramRdEn   <= 1'b0;
      paramWrEn   <= 1'b0;
      paramWrData <= 32'h0000_0000;
      wrRejected  <= 1'b0;
      wrCnt_reg   <= 16'h0000;
    end
    else
    begin
      paramRdEn  <= 1'b0;
      paramWrEn  <= 1'b0;
      wrRejected <= 1'b0;
      if (state_reg == RWTS_IDLE)
        wrCnt_reg <= 16'h0000;
      if (rdStep && (!blkWide || !half_reg))
        paramRdEn <= 1'b1;
      if (wrStep && !blkWide)
      begin
        paramWrEn   <= 1'b1;
        paramWrData <= {{16{wrWord[15]}}, wrWord};
        wrCnt_reg   <= wrCnt_reg + 16'h0001;
      end
      else if (wrStep && half_reg && inRange)
      begin
        paramWrEn   <= 1'b1;
        paramWrData <= wideValue;
        wrCnt_reg   <= wrCnt_reg + 16'h0002;
      end
      else if (wrStep && half_reg)
        wrRejected <= 1'b1;
    end
  end

  // completion and exception answer
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      excValid  <= 1'b0;
      excFunc   <= 8'h00;
      excCode   <= `RWTS_EXC_NONE;
      doneValid <= 1'b0;
      doneCount <= 16'h0000;
    end
    else
    begin
      excValid  <= 1'b0;
      doneValid <= 1'b0;
      if (state_reg == RWTS_IDLE && reqValid && decExc != `RWTS_EXC_NONE)
      begin
        excValid <= 1'b1;
        excFunc  <= reqFunc | (8'h01 << `RWTS_EXC_FC_BIT);
        excCode  <= decExc;
      end
      if (state_reg == RWTS_DONE)
      begin
        doneValid <= 1'b1;
        doneCount <= wrCnt_reg;
      end
    end
  end

  chk_exc_odd_wide: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == RWTS_IDLE && reqValid && funcKnown && decWide && reqCount[0])
    |=> excValid && excCode == `RWTS_EXC_RANGE) else $error("odd wide count accepted");
  chk_exc_reserved: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == RWTS_IDLE && reqValid && funcKnown && reqAddr[15:14] == 2'b11)
    |=> excValid && excCode == `RWTS_EXC_RANGE) else $error("reserved type accepted");
  chk_exc_func_bit: assert property (@(posedge clk) disable iff (sys_rst)
    excValid |-> excFunc[7]) else $error("exception function bit clear");
  chk_exc_no_access: assert property (@(posedge clk) disable iff (sys_rst)
    excValid |-> ##1 (!paramRdEn && !paramWrEn) [*2]) else $error("access after exception");
  chk_narrow_write: assert property (@(posedge clk) disable iff (sys_rst)
    (wrStep && !blkWide) |=> paramWrEn && paramWrData == {{16{$past(wrWord[15])}},
    $past(wrWord)}) else $error("narrow write not sign extended");
  chk_wide_range: assert property (@(posedge clk) disable iff (sys_rst)
    (wrStep && blkWide && half_reg && !inRange) |=> !paramWrEn && wrRejected)
    else $error("out of range write accepted");
  chk_low_word: assert property (@(posedge clk) disable iff (sys_rst)
    (rdStep && !blkWide) |=> rdWordValid && rdWord == $past(paramRdData[15:0]))
    else $error("narrow read not low word");
  chk_sign_ext: assert property (@(posedge clk) disable iff (sys_rst)
    (rdStep && blkWide && !half_reg && !paramIs32) |=> rdWord == {16{$past(paramRdData[15])}})
    else $error("wide read not sign extended");
  chk_type_held: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == RWTS_READ) |=> $stable(blkType_reg)) else $error("type changed in block");
  chk_wide_pair: assert property (@(posedge clk) disable iff (sys_rst)
    (rdStep && blkWide && !half_reg) |=> $stable(paramAddr)) else $error("pair split");
  chk_wide_hi_word: assert property (@(posedge clk) disable iff (sys_rst)
    (rdStep && blkWide && !half_reg && paramIs32) |=> rdWord == $past(paramRdData[31:16]))
    else $error("wide read high word wrong");
  chk_wide_lo_word: assert property (@(posedge clk) disable iff (sys_rst)
    (rdStep && blkWide && half_reg) |=> rdWord == $past(paramRdData[15:0]))
    else $error("wide read low word wrong");
  chk_wide_wr_data: assert property (@(posedge clk) disable iff (sys_rst)
    (wrStep && blkWide && half_reg && inRange) |=> paramWrEn
    && paramWrData == {$past(hiWord_reg), $past(wrWord)}) else $error("wide write data wrong");
  chk_half_no_write: assert property (@(posedge clk) disable iff (sys_rst)
    (wrStep && blkWide && !half_reg) |=> !paramWrEn)
    else $error("write issued after first word");
  chk_narrow_advance: assert property (@(posedge clk) disable iff (sys_rst)
    (rdStep && !blkWide) |=> paramAddr == $past(paramAddr) + 14'h0001)
    else $error("narrow read pointer not advanced");
  chk_func_reject: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == RWTS_IDLE && reqValid && !funcKnown)
    |=> excValid && excCode == `RWTS_EXC_FUNC) else $error("unknown function accepted");
  chk_count_limit: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == RWTS_IDLE && reqValid && funcKnown && reqCount > `RWTS_MAX_REGS)
    |=> excValid && excCode == `RWTS_EXC_RANGE) else $error("too many registers accepted");
  chk_single_narrow: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == RWTS_IDLE && reqValid && reqFunc == `RWTS_FC_WRSINGLE && decWide)
    |=> excValid && excCode == `RWTS_EXC_RANGE) else $error("wide single write accepted");
  chk_exc_func_echo: assert property (@(posedge clk) disable iff (sys_rst)
    excValid |-> excFunc[6:0] == $past(reqFunc[6:0]))
    else $error("exception function not echoed");
endmodule : rwts_width_select

// [design/rwts_defs.svh]
// constants for the register width and type select decoder
// assumes a single 125 MHz system clock and a host framer around it
`ifndef RWTS_DEFS_SVH
`define RWTS_DEFS_SVH
`define RWTS_TYPE_HI      15
`define RWTS_TYPE_LO      14
`define RWTS_INDEX_MSB    13
`define RWTS_EXC_FC_BIT   7
`define RWTS_EXC_NONE     8'h00
`define RWTS_EXC_FUNC     8'h01
`define RWTS_EXC_RANGE    8'h02
`define RWTS_FC_READ      8'h03
`define RWTS_FC_WRSINGLE  8'h06
`define RWTS_FC_WRMULTI   8'h10
`define RWTS_FC_RDWR      8'h17
`define RWTS_CRC_POLY     16'hA001
`define RWTS_CRC_INIT     16'hFFFF
`define RWTS_MAX_REGS     16'h0010
`define RWTS_NUM_PARAMS   14'h0BB8
`define RWTS_FLOAT_OK     1'b1
`endif

// [design/rwts_pkg.sv]
// types for the register width and type select decoder
// assumes rwts_defs.svh for numeric constants
package rwts_pkg;
  typedef enum logic [1:0] {
    RWTS_INT16   = 2'h0,
    RWTS_INT32   = 2'h1,
    RWTS_FLOAT32 = 2'h2,
    RWTS_RSVD    = 2'h3
  } rwts_type_t;

  typedef enum logic [4:0] {
    RWTS_IDLE  = 5'h01,
    RWTS_READ  = 5'h02,
    RWTS_WRITE = 5'h04,
    RWTS_DONE  = 5'h08,
    RWTS_ERR   = 5'h10
  } rwts_state_t;
endpackage : rwts_pkg

// [design/rwts_crc16.sv]
// byte-wide frame check generator
// assumes bytes are presented one per enable pulse
`timescale 1ns/1ns
`include "rwts_defs.svh"
module rwts_crc16
  import rwts_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        crcClear,
  input  wire logic        crcByteValid,
  input  wire logic [7:0]  crcByte,
  output logic      [15:0] crcValue
);
  logic [15:0] crcNext;

  always_comb
  begin
    crcNext = crcValue ^ {8'h00, crcByte};
    for (int i = 0; i < 8; i++)
    begin
      crcNext = crcNext[0] ? ((crcNext >> 1) ^ `RWTS_CRC_POLY) : (crcNext >> 1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      crcValue <= `RWTS_CRC_INIT;
    else if (crcClear)
      crcValue <= `RWTS_CRC_INIT;
    else if (crcByteValid)
      crcValue <= crcNext;
  end

  chk_crc_clear_init: assert property (@(posedge clk) disable iff (sys_rst)
    crcClear |=> crcValue == `RWTS_CRC_INIT) else $error("crc not reset");
endmodule : rwts_crc16

// [design/rwts_decode.sv]
// address split and request checks for a block access
// assumes the start address and count are stable while reqValid
`timescale 1ns/1ns
`include "rwts_defs.svh"
module rwts_decode
  import rwts_pkg::*;
(
  input  wire logic [15:0] startAddr,
  input  wire logic [15:0] regCount,
  input  wire logic [7:0]  funcCode,
  output rwts_type_t       selType,
  output logic      [13:0] paramIndex,
  output logic             isWide,
  output logic      [7:0]  excCode
);
  logic [15:0] paramSpan;
  logic        multiSvc;

  assign selType    = rwts_type_t'(startAddr[`RWTS_TYPE_HI:`RWTS_TYPE_LO]);
  assign paramIndex = startAddr[`RWTS_INDEX_MSB:0];
  assign isWide     = (selType == RWTS_INT32) || (selType == RWTS_FLOAT32);
  assign paramSpan  = isWide ? {1'b0, regCount[15:1]} : regCount;
  assign multiSvc   = (funcCode == `RWTS_FC_READ) || (funcCode == `RWTS_FC_WRMULTI)
                      || (funcCode == `RWTS_FC_RDWR);

  always_comb
  begin
    excCode = `RWTS_EXC_NONE;
    if (!multiSvc && funcCode != `RWTS_FC_WRSINGLE)
      excCode = `RWTS_EXC_FUNC;
    else if (selType == RWTS_RSVD)
      excCode = `RWTS_EXC_RANGE;
    else if (selType == RWTS_FLOAT32 && !`RWTS_FLOAT_OK)
      excCode = `RWTS_EXC_RANGE;
    else if (isWide && !multiSvc)
      excCode = `RWTS_EXC_RANGE;
    else if (isWide && regCount[0])
      excCode = `RWTS_EXC_RANGE;
    else if (regCount == 16'h0000 || regCount > `RWTS_MAX_REGS)
      excCode = `RWTS_EXC_RANGE;
    else if ({2'b00, paramIndex} + paramSpan > {2'b00, `RWTS_NUM_PARAMS})
      excCode = `RWTS_EXC_RANGE;
  end
endmodule : rwts_decode

// [tb/rwts_store_model.sv]
// parameter store model for the width select engine
// assumes reads are combinational and writes land one cycle after the address
`timescale 1ns/1ns
module rwts_store_model
  import rwts_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               paramWrEn,
  input  wire logic        [13:0] paramAddr,
  input  wire logic        [31:0] paramWrData,
  output logic             [31:0] paramRdData,
  output logic                    paramIs32,
  output logic signed      [31:0] paramMin,
  output logic signed      [31:0] paramMax
);
  logic [31:0] mem [0:3];
  logic [13:0] addrPrevReg;
  logic [1:0]  slot;
  // four parameters from index 127; slots 0 and 3 are wide
  assign slot        = 2'(paramAddr - 14'h007F);
  assign paramRdData = mem[slot];
  assign paramIs32   = (slot == 2'h0) || (slot == 2'h3);
  assign paramMax    = paramIs32 ? 32'sh000186A0 : 32'sh00002710;
  assign paramMin    = -paramMax;
  initial
  begin
    mem[0] = 32'h12345678;
    mem[1] = 32'hFFFFABCD;
    mem[2] = 32'h00000123;
    mem[3] = 32'h00000000;
  end
  // write refers to the address of the previous cycle
  always @(posedge clk)
  begin
    addrPrevReg <= paramAddr;
    if (paramWrEn)
      mem[2'(addrPrevReg - 14'h007F)] <= paramWrData;
  end
endmodule : rwts_store_model

// [tb/tb_register_width_type_select.sv]
// self-checking bench for the width select engine
// assumes the store model answers on the parameter side
`timescale 1ns/1ns
module tb_register_width_type_select;
  import rwts_pkg::*;
  typedef struct {
    logic [7:0]  fn;
    logic [15:0] adr;
    logic [15:0] cnt;
    logic [7:0]  exc;
    logic [63:0] w;
  } rwts_row_t;
  logic               clk, sys_rst, reqValid, wrWordValid, paramIs32;
  logic        [7:0]  reqFunc;
  logic        [15:0] reqAddr, reqCount, wrWord, rdWord, doneCount, crcValue;
  logic        [31:0] paramRdData, paramWrData;
  logic signed [31:0] paramMin, paramMax;
  logic               reqReady, paramRdEn, paramWrEn, rdWordValid, wrRejected;
  logic               excValid, doneValid;
  logic        [13:0] paramAddr;
  logic        [7:0]  excFunc, excCode, gotExc, gotFn;
  logic        [15:0] got [$];
  logic        [15:0] gotCnt;
  logic               gotRej;
  int                 n_fail, checked;
  int                 gotRd, nPar;
  logic        [15:0] crcExp;
  rwts_row_t          rows [12];

  rwts_width_select i_rwts_width_select (.clk, .sys_rst, .reqValid, .reqFunc, .reqAddr,
    .reqCount, .wrWordValid, .wrWord, .paramRdData, .paramIs32, .paramMin, .paramMax,
    .reqReady, .paramRdEn, .paramWrEn, .paramAddr, .paramWrData, .rdWordValid, .rdWord,
    .wrRejected, .excValid, .excFunc, .excCode, .doneValid, .doneCount, .crcValue);
  rwts_store_model i_rwts_store_model (.clk, .paramWrEn, .paramAddr, .paramWrData,
    .paramRdData, .paramIs32, .paramMin, .paramMax);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic report_and_stop();
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // reflected frame check step, polynomial x16+x15+x2+1
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    return r;
  endfunction : crc_step

  // one request, then words out and answers in until the block ends
  task automatic run(input logic [7:0] fn, input logic [15:0] adr, input logic [15:0] cnt,
                     input logic [63:0] wv);
    int wi;
    bit fin;
    wi = 0;
    fin = 0;
    got.delete();
    gotExc = 8'h00;
    gotFn = 8'h00;
    gotRej = 1'b0;
    gotCnt = 16'h0000;
    gotRd = 0;
    for (int k = 0; k < 20 && reqReady !== 1'b1; k++)
      @(negedge clk);
    if (reqReady !== 1'b1)
    begin
      n_fail++;
      report_and_stop();
    end
    reqValid = 1'b1;
    reqFunc = fn;
    reqAddr = adr;
    reqCount = cnt;
    @(negedge clk);
    reqValid = 1'b0;
    for (int k = 0; k < 80 && !fin; k++)
    begin
      if (rdWordValid === 1'b1)
        got.push_back(rdWord);
      if (paramRdEn === 1'b1)
        gotRd++;
      if (wrRejected === 1'b1)
        gotRej = 1'b1;
      if (excValid === 1'b1)
      begin
        gotExc = excCode;
        gotFn = excFunc;
        fin = 1;
      end
      if (doneValid === 1'b1)
      begin
        gotCnt = doneCount;
        fin = 1;
      end
      // master counts 16-bit words, two per wide parameter
      wrWordValid = (fn == 8'h10 || fn == 8'h06 || fn == 8'h17) && k[0] && wi < int'(cnt)
                    && !fin;
      wrWord = wv[63 - 16 * (wi & 3) -: 16];
      if (wrWordValid)
        wi++;
      @(negedge clk);
    end
    wrWordValid = 1'b0;
    if (!fin)
    begin
      n_fail++;
      report_and_stop();
    end
    @(negedge clk);
  endtask : run

  initial
  begin
    n_fail = 0;
    checked = 0;
    sys_rst = 1'b1;
    reqValid = 1'b0;
    reqFunc = 8'h00;
    reqAddr = 16'h0000;
    reqCount = 16'h0000;
    wrWordValid = 1'b0;
    wrWord = 16'h0000;
    rows = '{
      '{8'h03, 16'h007F, 16'h0001, 8'h00, 64'h5678_0000_0000_0000},
      '{8'h03, 16'h407F, 16'h0002, 8'h00, 64'h1234_5678_0000_0000},
      '{8'h03, 16'h407F, 16'h0001, 8'h02, 64'h0},
      '{8'h03, 16'h0080, 16'h0001, 8'h00, 64'hABCD_0000_0000_0000},
      '{8'h03, 16'h4080, 16'h0002, 8'h00, 64'hFFFF_ABCD_0000_0000},
      '{8'h03, 16'h4081, 16'h0002, 8'h00, 64'h0000_0123_0000_0000},
      '{8'h03, 16'h007F, 16'h0002, 8'h00, 64'h5678_ABCD_0000_0000},
      '{8'h03, 16'h407F, 16'h0004, 8'h00, 64'h1234_5678_FFFF_ABCD},
      '{8'h03, 16'h807F, 16'h0002, 8'h00, 64'h1234_5678_0000_0000},
      '{8'h03, 16'hC07F, 16'h0002, 8'h02, 64'h0},
      '{8'h03, 16'h007F, 16'h0011, 8'h02, 64'h0},
      '{8'h06, 16'h407F, 16'h0001, 8'h02, 64'h0}
    };
    repeat (2) @(negedge clk);
    chk("reqReady in reset", 32'(reqReady), 32'h00000001);
    chk("crcValue in reset", 32'(crcValue), 32'h0000FFFF);
    sys_rst = 1'b0;
    foreach (rows[i])
    begin
      run(rows[i].fn, rows[i].adr, rows[i].cnt, rows[i].w);
      chk("exception code", 32'(gotExc), 32'(rows[i].exc));
      chk("exception function", 32'(gotFn), rows[i].exc != 0 ? 32'(rows[i].fn | 8'h80) : 0);
      chk("word count", got.size(), rows[i].exc != 0 ? 0 : int'(rows[i].cnt));
      for (int j = 0; j < got.size() && j < 4; j++)
        chk("read word", 32'(got[j]), 32'(rows[i].w[63 - 16 * j -: 16]));
      nPar = int'(rows[i].adr[15:14] != 2'b00 ? rows[i].cnt / 16'h0002 : rows[i].cnt);
      if (rows[i].exc != 0)
        nPar = 0;
      chk("read strobes", gotRd, nPar);
      chk("parameter pointer", 32'(paramAddr), 32'(rows[i].adr[13:0]) + nPar);
      crcExp = 16'hFFFF;
      for (int j = 0; j < 4 && rows[i].exc == 0 && j < int'(rows[i].cnt); j++)
        crcExp = crc_step(crcExp, rows[i].w[55 - 16 * j -: 8]);
      chk("frame check", 32'(crcValue), 32'(crcExp));
    end
    run(8'h03, 16'h0BB7, 16'h0002, 64'h0);
    chk("address beyond range", 32'({gotFn, gotExc}), 32'h00008302);
    run(8'h05, 16'h007F, 16'h0001, 64'h0);
    chk("unknown function", 32'({gotFn, gotExc}), 32'h00008501);
    run(8'h10, 16'h007F, 16'h0001, 64'hABCD_0000_0000_0000);
    chk("narrow write wide", i_rwts_store_model.mem[0], 32'hFFFFABCD);
    chk("written count", 32'(gotCnt), 32'h00000001);
    run(8'h10, 16'h407F, 16'h0002, 64'h0000_1234_0000_0000);
    chk("wide write wide", i_rwts_store_model.mem[0], 32'h00001234);
    run(8'h10, 16'h4080, 16'h0002, 64'h0000_0123_0000_0000);
    chk("wide write narrow", i_rwts_store_model.mem[1], 32'h00000123);
    chk("written count", 32'(gotCnt), 32'h00000002);
    run(8'h10, 16'h4080, 16'h0002, 64'h0001_86A0_0000_0000);
    chk("range reject", 32'(gotRej), 32'h00000001);
    chk("value kept", i_rwts_store_model.mem[1], 32'h00000123);
    chk("written count", 32'(gotCnt), 32'h00000000);
    run(8'h06, 16'h0080, 16'h0001, 64'h0055_0000_0000_0000);
    chk("single write", i_rwts_store_model.mem[1], 32'h00000055);
    run(8'h17, 16'h4081, 16'h0002, 64'hFFFF_FFF0_0000_0000);
    chk("read write service", i_rwts_store_model.mem[2], 32'hFFFFFFF0);
    chk("written count", 32'(gotCnt), 32'h00000002);
    reqValid = 1'b1;
    reqFunc = 8'h03;
    reqAddr = 16'h407F;
    reqCount = 16'h0004;
    @(negedge clk);
    reqValid = 1'b0;
    @(negedge clk);
    sys_rst = 1'b1;
    @(negedge clk);
    chk("reqReady after reset", 32'(reqReady), 32'h00000001);
    chk("rdWordValid after reset", 32'(rdWordValid), 32'h00000000);
    chk("crcValue after reset", 32'(crcValue), 32'h0000FFFF);
    sys_rst = 1'b0;
    run(8'h03, 16'h007F, 16'h0001, 64'h0);
    chk("read after reset", 32'(got.size() > 0 ? got[0] : 16'h0000), 32'h00001234);
    report_and_stop();
  end
endmodule : tb_register_width_type_select
